//--- verilog/async_waveform_timer.sv
// Waveform timer front end: register categories, crossings and 12-bit core
//
// What this block does
// - Twelve-bit counter in the core domain, separate from the bus side.
// - Two compare units with own outputs, plus two mirroring outputs.
// - Counter compared continuously; set matches and overflow raise flags, and events where interrupts are enabled.
// - Ten input modes per input event (mode 0 off), steering the outputs only, not the counter.
// - Four clock sources and three separately controlled prescalers.
// - Crossing counts CROSS_CYCLES cycles of i_clk; there is no separate synchronizer clock.
// - Counter clock divided by sync factor times counter factor.
// - Delay prescaler only for blanking and delayed event; others in control A.
// - Each register category crosses into the core its own way.
// - Control A non-enable bits written only with enable already zero.
// - Enable changes only while enable-ready is one.
// - Command register crosses automatically when enabled and no crossing busy.
// - Command bits clear themselves once delivered to the core.
// - Buffered writes while enabled only when command-ready; load on sync/enable.
// - Static registers frozen while enabled.
`timescale 1ns/100ps
module async_waveform_timer
   import waveform_timer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_control_reg_a_wr,
   input wire logic i_control_reg_a_enable,
   input wire logic [1:0] i_clk_sel,
   input wire logic [1:0] i_sync_presc,
   input wire logic [1:0] i_cnt_presc,
   input wire logic [NUM_EXT_SRC-1:0] i_ext_src,
   input wire logic i_static_wr,
   input wire logic [2:0] i_static_sel,
   input wire logic [REG_W-1:0] i_static_data,
   input wire logic i_dbuf_wr,
   input wire logic [3:0] i_dbuf_sel,
   input wire logic [CNT_W-1:0] i_dbuf_data,
   input wire logic i_cmd_wr,
   input wire logic [CMD_W-1:0] i_cmd_data,
   input wire logic [FLAG_W-1:0] i_int_enable,
   input wire logic [FLAG_W-1:0] i_flag_clear,
   input wire logic i_event_a,
   input wire logic i_event_b,
   output logic o_wave_out_first,
   output logic o_wave_out_second,
   output logic o_wave_out_third,
   output logic o_wave_out_fourth,
   output logic o_enable_ready_flag,
   output logic o_command_ready_status,
   output logic o_enabled,
   output logic [CNT_W-1:0] o_count,
   output logic [CNT_W-1:0] o_capture_value_a,
   output logic [CNT_W-1:0] o_capture_value_b,
   output logic [FLAG_W-1:0] o_interrupt_flag_reg,
   output logic [FLAG_W-1:0] o_flag_event,
   output logic o_delay_tick
);
   typedef struct packed {
      logic en_bus;
      logic [1:0] clk_sel;
      logic [1:0] sync_presc;
      logic [1:0] cnt_presc;
      logic [NUM_STAT-1:0][REG_W-1:0] stat;
      logic [NUM_DBUF-1:0][CNT_W-1:0] dbuf;
      logic [NUM_DBUF-1:0][CNT_W-1:0] dcore;
      logic [CMD_W-1:0] cmd;
      logic [CMD_W-1:0] cmd_core;
      logic [2:0] en_cnt;
      logic [2:0] cmd_cnt;
      logic en_target;
      logic core_en;
      logic enable_ready_flag;
      logic command_ready_status;
      logic [CNT_W-1:0] count;
      logic wave_a;
      logic wave_b;
      logic wave_c;
      logic wave_d;
      logic [1:0] blocked;
      logic [CNT_W-1:0] cap_a;
      logic [CNT_W-1:0] cap_b;
      logic [FLAG_W-1:0] flags;
      logic [FLAG_W-1:0] fevt;
   } timer_t;

   timer_t q_ff;
   timer_t nxt_q;
   logic cnt_tick;
   logic dly_tick;

   // ---------------------------------------------------------------
   // Clock sources and prescalers
   // ---------------------------------------------------------------
   waveform_prescaler u_presc (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_run(q_ff.core_en),
      .i_clk_sel(q_ff.clk_sel),
      .i_ext_src(i_ext_src),
      .i_sync_presc(q_ff.sync_presc),
      .i_cnt_presc(q_ff.cnt_presc),
      .i_dly_presc(q_ff.dcore[DBUF_DLY_CTRL][DLY_PRESC_LSB +: 2]),
      .o_cnt_tick(cnt_tick),
      .o_dly_tick(dly_tick)
   );

   function automatic logic input_active(input logic ev, input logic [REG_W-1:0] evc,
                                         input logic [REG_W-1:0] inc);
      logic [3:0] mode;
      mode = inc[IN_MODE_LSB +: 4];
      return ev && evc[EV_TRIG_BIT] && (mode != 4'h0) && (mode <= IN_MODE_MAX);
   endfunction

   always_comb begin
      logic wrap;
      logic apply_sync;
      logic restart;
      logic [CNT_W-1:0] cmp_a_set;
      logic [CNT_W-1:0] cmp_a_clr;
      logic [CNT_W-1:0] cmp_b_set;
      logic [CNT_W-1:0] cmp_b_clr;
      logic [FLAG_W-1:0] hit;
      nxt_q = q_ff;
      wrap = 1'b0;
      apply_sync = 1'b0;
      restart = 1'b0;
      hit = '0;
      cmp_a_set = q_ff.dcore[DBUF_CMPA_SET];
      cmp_a_clr = q_ff.dcore[DBUF_CMPA_CLR];
      cmp_b_set = q_ff.dcore[DBUF_CMPB_SET];
      cmp_b_clr = q_ff.dcore[DBUF_CMPB_CLR];
      // ---------------------------------------------------------------
      // Bus side writes
      // ---------------------------------------------------------------
      if (i_control_reg_a_wr) begin
         if (!q_ff.en_bus) begin
            nxt_q.clk_sel = i_clk_sel;
            nxt_q.sync_presc = i_sync_presc;
            nxt_q.cnt_presc = i_cnt_presc;
         end
         // Enable flips only with no enable crossing in flight
         if (q_ff.enable_ready_flag && (i_control_reg_a_enable != q_ff.en_bus)) begin
            nxt_q.en_bus = i_control_reg_a_enable;
            nxt_q.en_target = i_control_reg_a_enable;
            nxt_q.en_cnt = CROSS_CYCLES;
            nxt_q.enable_ready_flag = 1'b0;
         end
      end
      if (i_static_wr && !q_ff.core_en && !q_ff.en_bus) begin
         nxt_q.stat[i_static_sel] = i_static_data;
      end
      if (i_dbuf_wr && (i_dbuf_sel < 4'(NUM_DBUF)) && (!q_ff.core_en || q_ff.command_ready_status)) begin
         nxt_q.dbuf[i_dbuf_sel] = i_dbuf_data;
      end
      if (i_cmd_wr && q_ff.command_ready_status) begin
         nxt_q.cmd = q_ff.cmd | i_cmd_data;
      end
      // ---------------------------------------------------------------
      // Crossings into the core
      // ---------------------------------------------------------------
      if (q_ff.en_cnt != 3'h0) begin
         nxt_q.en_cnt = q_ff.en_cnt - 3'h1;
         if (q_ff.en_cnt == 3'h1) begin
            nxt_q.core_en = q_ff.en_target;
            nxt_q.enable_ready_flag = 1'b1;
            if (q_ff.en_target) begin
               nxt_q.dcore = q_ff.dbuf;
               nxt_q.count = '0;
               nxt_q.cmd_core = '0;
            end
         end
      end else if (q_ff.cmd_cnt != 3'h0) begin
         nxt_q.cmd_cnt = q_ff.cmd_cnt - 3'h1;
         if (q_ff.cmd_cnt == 3'h1) begin
            nxt_q.cmd_core = q_ff.cmd_core | q_ff.cmd;
            nxt_q.cmd = '0;
            if (q_ff.cmd[CMD_SYNC]) begin
               apply_sync = 1'b1;
            end
            if (q_ff.cmd[CMD_RESTART]) begin
               restart = 1'b1;
            end
         end
      end else if (q_ff.core_en && (q_ff.cmd != '0) && !(i_control_reg_a_wr && q_ff.enable_ready_flag)) begin
         nxt_q.cmd_cnt = CROSS_CYCLES;
      end
      nxt_q.command_ready_status = (nxt_q.cmd == '0) && (nxt_q.cmd_cnt == 3'h0);
      // ---------------------------------------------------------------
      // Core counter, one ramp
      // ---------------------------------------------------------------
      if (q_ff.core_en && cnt_tick) begin
         if (q_ff.count == cmp_b_clr) begin
            wrap = 1'b1;
            nxt_q.count = '0;
            hit[FLAG_OVF] = 1'b1;
            nxt_q.wave_a = 1'b0;
            nxt_q.wave_b = 1'b0;
            nxt_q.blocked = 2'h0;
         end else begin
            nxt_q.count = q_ff.count + 12'h001;
            if (q_ff.count == cmp_a_set) begin
               hit[FLAG_CMPA] = 1'b1;
               nxt_q.wave_a = !q_ff.blocked[0];
            end else if (q_ff.count == cmp_a_clr) begin
               nxt_q.wave_a = 1'b0;
            end
            if (q_ff.count == cmp_b_set) begin
               hit[FLAG_CMPB] = 1'b1;
               nxt_q.wave_b = !q_ff.blocked[1];
            end
         end
      end
      // Restart must win over a counter tick in the same cycle
      if (restart) begin
         nxt_q.count = '0;
      end
      if (wrap && (q_ff.cmd_core[CMD_SYNC_EOC] || nxt_q.cmd_core[CMD_SYNC_EOC])) begin
         apply_sync = 1'b1;
         nxt_q.cmd_core[CMD_SYNC_EOC] = 1'b0;
      end
      if (wrap && q_ff.cmd_core[CMD_DIS_EOC]) begin
         nxt_q.core_en = 1'b0;
         nxt_q.en_bus = 1'b0;
         nxt_q.cmd_core[CMD_DIS_EOC] = 1'b0;
      end
      if (apply_sync) begin
         nxt_q.dcore = q_ff.dbuf;
      end
      // ---------------------------------------------------------------
      // Input events: outputs held off to cycle end, or capture
      // ---------------------------------------------------------------
      if (q_ff.core_en) begin
         if (input_active(i_event_a, q_ff.stat[STAT_EV_A], q_ff.stat[STAT_IN_A])) begin
            nxt_q.wave_a = 1'b0;
            nxt_q.blocked[0] = 1'b1;
         end
         if (input_active(i_event_b, q_ff.stat[STAT_EV_B], q_ff.stat[STAT_IN_B])) begin
            nxt_q.wave_b = 1'b0;
            nxt_q.blocked[1] = 1'b1;
         end
         if (i_event_a && q_ff.stat[STAT_EV_A][EV_ACTION_BIT]) begin
            nxt_q.cap_a = q_ff.count;
         end
         if (i_event_b && q_ff.stat[STAT_EV_B][EV_ACTION_BIT]) begin
            nxt_q.cap_b = q_ff.count;
         end
      end else begin
         nxt_q.wave_a = 1'b0;
         nxt_q.wave_b = 1'b0;
      end
      // Mirror outputs follow the next value so all four switch together
      nxt_q.wave_c = q_ff.stat[STAT_CTRL_C][MIRROR_THIRD_BIT] ? nxt_q.wave_b : nxt_q.wave_a;
      nxt_q.wave_d = q_ff.stat[STAT_CTRL_C][MIRROR_FOURTH_BIT] ? nxt_q.wave_b : nxt_q.wave_a;
      // Set beats a clear arriving in the same cycle
      nxt_q.flags = (q_ff.flags & ~i_flag_clear) | hit;
      nxt_q.fevt = hit & i_int_enable;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_ff <= '0;
         q_ff.enable_ready_flag <= 1'b1;
         q_ff.command_ready_status <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_wave_out_first = q_ff.wave_a;
   assign o_wave_out_second = q_ff.wave_b;
   assign o_wave_out_third = q_ff.wave_c;
   assign o_wave_out_fourth = q_ff.wave_d;
   assign o_enable_ready_flag = q_ff.enable_ready_flag;
   assign o_command_ready_status = q_ff.command_ready_status;
   assign o_enabled = q_ff.core_en;
   assign o_count = q_ff.count;
   assign o_capture_value_a = q_ff.cap_a;
   assign o_capture_value_b = q_ff.cap_b;
   assign o_interrupt_flag_reg = q_ff.flags;
   assign o_flag_event = q_ff.fevt;
   assign o_delay_tick = dly_tick;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   chk_enable_ready_flag_cross_low: assert property (
      (i_control_reg_a_wr && o_enable_ready_flag && (i_control_reg_a_enable != q_ff.en_bus))
      |=> !o_enable_ready_flag [*3] ##1 o_enable_ready_flag)
      else $error("enable-ready not low for exactly the crossing");
   chk_enable_applied: assert property (
      (i_control_reg_a_wr && o_enable_ready_flag && (i_control_reg_a_enable != q_ff.en_bus)
       && (q_ff.cmd_core == '0))
      |-> ##4 (o_enabled == $past(i_control_reg_a_enable, 4)))
      else $error("enable did not reach core after crossing");
   chk_enable_gated: assert property (
      (i_control_reg_a_wr && !o_enable_ready_flag) |=> $stable(q_ff.en_target))
      else $error("enable changed while not ready");
   chk_static_frozen: assert property (
      o_enabled |=> $stable(q_ff.stat))
      else $error("static register changed while enabled");
   chk_control_reg_a_locked: assert property (
      q_ff.en_bus |=> $stable({q_ff.clk_sel, q_ff.sync_presc, q_ff.cnt_presc}))
      else $error("control A changed while enable set");
   chk_cmd_clears: assert property (
      (q_ff.cmd_cnt == 3'h1) |=> (q_ff.cmd == '0) && o_command_ready_status)
      else $error("command bits not cleared on delivery");
   chk_cmd_launch: assert property (
      (o_enabled && (q_ff.cmd != '0) && (q_ff.en_cnt == 3'h0) && (q_ff.cmd_cnt == 3'h0)
       && !i_control_reg_a_wr) |=> (q_ff.cmd_cnt == CROSS_CYCLES))
      else $error("command crossing did not start");
   chk_dbuf_locked: assert property (
      (o_enabled && !o_command_ready_status) |=> $stable(q_ff.dbuf))
      else $error("buffered register written during crossing");
   chk_count_wrap: assert property (
      (o_enabled && cnt_tick && (o_count == q_ff.dcore[DBUF_CMPB_CLR])
       && (q_ff.cmd_cnt != 3'h1))
      |=> (o_count == 12'h000) && o_interrupt_flag_reg[FLAG_OVF])
      else $error("counter did not wrap with overflow flag");
   chk_mirror_third: assert property (
      o_wave_out_third == ($past(q_ff.stat[STAT_CTRL_C][MIRROR_THIRD_BIT])
                           ? o_wave_out_second : o_wave_out_first))
      else $error("third output does not mirror its unit");
endmodule

//--- verilog/waveform_timer_pkg.sv
// Constants shared by the waveform timer front end and its prescaler
package waveform_timer_pkg;
   // ---------------------------------------------------------------
   // Widths and crossing latency
   // ---------------------------------------------------------------
   localparam int CNT_W = 12;
   localparam int REG_W = 8;
   localparam logic [2:0] CROSS_CYCLES = 3'h3;
   // ---------------------------------------------------------------
   // Double-buffered register indices
   // ---------------------------------------------------------------
   localparam int NUM_DBUF = 9;
   localparam int DBUF_DLY_CTRL = 0;
   localparam int DBUF_DLY_VAL = 1;
   localparam int DBUF_DIT_CTRL = 2;
   localparam int DBUF_DIT_VAL = 3;
   localparam int DBUF_DBG_CTRL = 4;
   localparam int DBUF_CMPA_SET = 5;
   localparam int DBUF_CMPA_CLR = 6;
   localparam int DBUF_CMPB_SET = 7;
   localparam int DBUF_CMPB_CLR = 8;
   localparam logic [CNT_W-1:0] DBUF_RESET = 12'h000;
   // ---------------------------------------------------------------
   // Static register indices
   // ---------------------------------------------------------------
   localparam int NUM_STAT = 8;
   localparam int STAT_CTRL_B = 0;
   localparam int STAT_CTRL_C = 1;
   localparam int STAT_CTRL_D = 2;
   localparam int STAT_EV_A = 3;
   localparam int STAT_EV_B = 4;
   localparam int STAT_IN_A = 5;
   localparam int STAT_IN_B = 6;
   localparam int STAT_FAULT = 7;
   localparam logic [REG_W-1:0] STAT_RESET = 8'h00;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MIRROR_THIRD_BIT = 0;
   localparam int MIRROR_FOURTH_BIT = 1;
   localparam int EV_TRIG_BIT = 0;
   localparam int EV_ACTION_BIT = 2;
   localparam int IN_MODE_LSB = 0;
   localparam logic [3:0] IN_MODE_MAX = 4'h9;
   localparam int DLY_PRESC_LSB = 4;
   localparam int CMD_W = 4;
   localparam int CMD_SYNC = 0;
   localparam int CMD_RESTART = 1;
   localparam int CMD_DIS_EOC = 2;
   localparam int CMD_SYNC_EOC = 3;
   localparam int FLAG_W = 3;
   localparam int FLAG_OVF = 0;
   localparam int FLAG_CMPA = 1;
   localparam int FLAG_CMPB = 2;
   // ---------------------------------------------------------------
   // Prescaler factors as shift amounts
   // ---------------------------------------------------------------
   localparam logic [2:0] CNT_DIV_LOG_0 = 3'h0;
   localparam logic [2:0] CNT_DIV_LOG_1 = 3'h2;
   localparam logic [2:0] CNT_DIV_LOG_2 = 3'h5;
   localparam int NUM_EXT_SRC = 3;
endpackage

//--- verilog/waveform_prescaler.sv
// Clock source selection and the synchronizer, counter and delay prescalers
`timescale 1ns/100ps
module waveform_prescaler
   import waveform_timer_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [1:0] i_clk_sel,
   input wire logic [NUM_EXT_SRC-1:0] i_ext_src,
   input wire logic [1:0] i_sync_presc,
   input wire logic [1:0] i_cnt_presc,
   input wire logic [1:0] i_dly_presc,
   output logic o_cnt_tick,
   output logic o_dly_tick
);
   typedef struct packed {
      logic [NUM_EXT_SRC-1:0] s1;
      logic [NUM_EXT_SRC-1:0] s2;
      logic [NUM_EXT_SRC-1:0] s3;
      logic [NUM_EXT_SRC-1:0] lvl;
      logic [2:0] syn_cnt;
      logic [4:0] cnt_cnt;
      logic [2:0] dly_cnt;
      logic cnt_tick;
      logic dly_tick;
   } presc_t;

   presc_t q_ff;
   presc_t nxt_q;

   function automatic logic [2:0] cnt_log(input logic [1:0] sel);
      if (sel == 2'h0) begin
         return CNT_DIV_LOG_0;
      end else if (sel == 2'h1) begin
         return CNT_DIV_LOG_1;
      end else begin
         return CNT_DIV_LOG_2;
      end
   endfunction

   always_comb begin
      logic [NUM_EXT_SRC-1:0] edge_hit;
      logic src_tick;
      logic sync_tick;
      logic [2:0] syn_lim;
      logic [4:0] cnt_lim;
      logic [2:0] dly_lim;
      nxt_q = q_ff;
      nxt_q.s1 = i_ext_src;
      nxt_q.s2 = q_ff.s1;
      nxt_q.s3 = q_ff.s2;
      // A rising pin change counts only once stages two and three agree
      for (int i = 0; i < NUM_EXT_SRC; i++) begin
         edge_hit[i] = (q_ff.s2[i] == q_ff.s3[i]) && q_ff.s2[i] && !q_ff.lvl[i];
         if (q_ff.s2[i] == q_ff.s3[i]) begin
            nxt_q.lvl[i] = q_ff.s2[i];
         end
      end
      src_tick = (i_clk_sel == 2'h0) ? 1'b1 : edge_hit[i_clk_sel - 2'h1];
      syn_lim = 3'((4'h1 << i_sync_presc) - 4'h1);
      cnt_lim = 5'((6'h01 << cnt_log(i_cnt_presc)) - 6'h01);
      dly_lim = 3'((4'h1 << i_dly_presc) - 4'h1);
      sync_tick = 1'b0;
      nxt_q.cnt_tick = 1'b0;
      nxt_q.dly_tick = 1'b0;
      if (!i_run) begin
         nxt_q.syn_cnt = 3'h0;
         nxt_q.cnt_cnt = 5'h00;
         nxt_q.dly_cnt = 3'h0;
      end else if (src_tick) begin
         // Counter clock is source divided by sync factor times count factor
         if (q_ff.syn_cnt >= syn_lim) begin
            nxt_q.syn_cnt = 3'h0;
            sync_tick = 1'b1;
         end else begin
            nxt_q.syn_cnt = q_ff.syn_cnt + 3'h1;
         end
      end
      if (i_run && sync_tick) begin
         if (q_ff.cnt_cnt >= cnt_lim) begin
            nxt_q.cnt_cnt = 5'h00;
            nxt_q.cnt_tick = 1'b1;
         end else begin
            nxt_q.cnt_cnt = q_ff.cnt_cnt + 5'h01;
         end
         // Delay prescaler runs apart, for blanking and delayed event out
         if (q_ff.dly_cnt >= dly_lim) begin
            nxt_q.dly_cnt = 3'h0;
            nxt_q.dly_tick = 1'b1;
         end else begin
            nxt_q.dly_cnt = q_ff.dly_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign o_cnt_tick = q_ff.cnt_tick;
   assign o_dly_tick = q_ff.dly_tick;
endmodule

//--- test/tb_async_waveform_timer.sv
// Self-checking bench for the waveform timer front end
`timescale 1ns/100ps
module tb_async_waveform_timer;
   import waveform_timer_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_control_reg_a_wr = 1'b0;
   logic i_control_reg_a_enable = 1'b0;
   logic [1:0] i_clk_sel = 2'h0;
   logic [1:0] i_sync_presc = 2'h0;
   logic [1:0] i_cnt_presc = 2'h0;
   logic i_static_wr = 1'b0;
   logic [2:0] i_static_sel = 3'h0;
   logic [REG_W-1:0] i_static_data = 8'h00;
   logic i_dbuf_wr = 1'b0;
   logic [3:0] i_dbuf_sel = 4'h0;
   logic [CNT_W-1:0] i_dbuf_data = 12'h000;
   logic i_cmd_wr = 1'b0;
   logic [CMD_W-1:0] i_cmd_data = 4'h0;
   logic [FLAG_W-1:0] i_int_enable = 3'h7;
   logic [FLAG_W-1:0] i_flag_clear = 3'h0;
   logic i_event_a = 1'b0;
   logic o_wave_out_first, o_wave_out_second, o_wave_out_third, o_wave_out_fourth;
   logic o_enable_ready_flag, o_command_ready_status, o_enabled, o_delay_tick;
   logic [CNT_W-1:0] o_count, o_capture_value_a, o_capture_value_b;
   logic [FLAG_W-1:0] o_interrupt_flag_reg, o_flag_event;
   int error_cnt = 0;
   int compares = 0;

   always #10 i_clk = ~i_clk;

   async_waveform_timer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_control_reg_a_wr(i_control_reg_a_wr),
      .i_control_reg_a_enable(i_control_reg_a_enable), .i_clk_sel(i_clk_sel), .i_sync_presc(i_sync_presc),
      .i_cnt_presc(i_cnt_presc), .i_ext_src(3'h0), .i_static_wr(i_static_wr),
      .i_static_sel(i_static_sel), .i_static_data(i_static_data), .i_dbuf_wr(i_dbuf_wr),
      .i_dbuf_sel(i_dbuf_sel), .i_dbuf_data(i_dbuf_data), .i_cmd_wr(i_cmd_wr),
      .i_cmd_data(i_cmd_data), .i_int_enable(i_int_enable), .i_flag_clear(i_flag_clear),
      .i_event_a(i_event_a), .i_event_b(1'b0), .o_wave_out_first(o_wave_out_first),
      .o_wave_out_second(o_wave_out_second), .o_wave_out_third(o_wave_out_third),
      .o_wave_out_fourth(o_wave_out_fourth), .o_enable_ready_flag(o_enable_ready_flag),
      .o_command_ready_status(o_command_ready_status), .o_enabled(o_enabled),
      .o_count(o_count), .o_capture_value_a(o_capture_value_a),
      .o_capture_value_b(o_capture_value_b), .o_interrupt_flag_reg(o_interrupt_flag_reg),
      .o_flag_event(o_flag_event), .o_delay_tick(o_delay_tick));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_control_reg_a(input logic en);
      @(posedge i_clk);
      i_control_reg_a_enable <= en;
      i_control_reg_a_wr <= 1'b1;
      @(posedge i_clk);
      i_control_reg_a_wr <= 1'b0;
      #1;
   endtask

   task automatic wr_static(input logic [2:0] sel, input logic [REG_W-1:0] d);
      @(posedge i_clk);
      i_static_sel <= sel;
      i_static_data <= d;
      i_static_wr <= 1'b1;
      @(posedge i_clk);
      i_static_wr <= 1'b0;
   endtask

   task automatic wr_dbuf(input int sel, input logic [CNT_W-1:0] d);
      @(posedge i_clk);
      i_dbuf_sel <= sel[3:0];
      i_dbuf_data <= d;
      i_dbuf_wr <= 1'b1;
      @(posedge i_clk);
      i_dbuf_wr <= 1'b0;
   endtask

   task automatic wr_cmd(input int bit_idx);
      @(posedge i_clk);
      i_cmd_data <= 4'h1 << bit_idx;
      i_cmd_wr <= 1'b1;
      @(posedge i_clk);
      i_cmd_wr <= 1'b0;
      #1;
   endtask

   // Bounded wait on a ready flag; a stuck flag ends up as a mismatch
   task automatic wait_rdy(input bit cmd);
      int n;
      n = 0;
      while ((cmd ? o_command_ready_status : o_enable_ready_flag) !== 1'b1 && n < 12) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check({11'h0, cmd ? o_command_ready_status : o_enable_ready_flag}, 12'h001);
   endtask

   task automatic wait_cnt(input logic [CNT_W-1:0] v, input int lim);
      int n;
      n = 0;
      while (o_count !== v && n < lim) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check(o_count, v);
   endtask

   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      check({9'h0, o_enable_ready_flag, o_command_ready_status, o_enabled}, 12'h006);
      check(o_count, 12'h000);
      $display("test_reset done");
   endtask

   // Statics and compares before enable, then the enable crossing
   task automatic test_enable;
      wr_static(STAT_CTRL_C[2:0], 8'h01);
      wr_static(STAT_EV_A[2:0], 8'h04);
      wr_static(STAT_FAULT[2:0], 8'h00);
      wr_dbuf(DBUF_CMPA_SET, 12'h001);
      wr_dbuf(DBUF_CMPA_CLR, 12'h003);
      wr_dbuf(DBUF_CMPB_SET, 12'h004);
      wr_dbuf(DBUF_CMPB_CLR, 12'h005);
      wr_control_reg_a(1'b1);
      check({11'h0, o_enable_ready_flag}, 12'h000);
      wr_control_reg_a(1'b0);
      wait_rdy(1'b0);
      check({11'h0, o_enabled}, 12'h001);
      $display("test_enable done");
   endtask

   // One ramp: wrap at the loaded period, outputs and mirrors
   task automatic test_wave;
      wr_static(STAT_CTRL_C[2:0], 8'h02);
      wait_cnt(12'h003, 20);
      check({8'h0, o_wave_out_first, o_wave_out_second, o_wave_out_third,
         o_wave_out_fourth}, 12'h009);
      wait_cnt(12'h005, 10);
      wait_cnt(12'h000, 4);
      check({9'h0, o_interrupt_flag_reg}, 12'h007);
      check({9'h0, o_flag_event}, 12'h001);
      check({11'h0, o_delay_tick}, 12'h001);
      @(posedge i_clk);
      i_flag_clear <= 3'h7;
      @(posedge i_clk);
      i_flag_clear <= 3'h0;
      #1;
      check({9'h0, o_interrupt_flag_reg & 3'h1}, 12'h000);
      @(posedge i_clk);
      i_event_a <= 1'b1;
      @(posedge i_clk);
      i_event_a <= 1'b0;
      #1;
      check(o_capture_value_a, 12'h003);
      $display("test_wave done");
   endtask

   // Buffered write stays out of the core until a sync command lands
   task automatic test_sync;
      int n;
      wr_dbuf(DBUF_CMPB_CLR, 12'h008);
      for (n = 0; n < 14; n++) begin
         @(posedge i_clk);
         #1;
         if (o_count > 12'h005) check(o_count, 12'h005);
      end
      wr_cmd(CMD_SYNC);
      check({11'h0, o_command_ready_status}, 12'h000);
      wr_cmd(CMD_RESTART);
      wait_rdy(1'b1);
      wait_cnt(12'h008, 30);
      wr_cmd(CMD_RESTART);
      wait_rdy(1'b1);
      check(o_count, 12'h000);
      $display("test_sync done");
   endtask

   task automatic test_disable;
      logic [CNT_W-1:0] held;
      wr_control_reg_a(1'b0);
      wait_rdy(1'b0);
      check({11'h0, o_enabled}, 12'h000);
      held = o_count;
      repeat (5) @(posedge i_clk);
      #1;
      check(o_count, held);
      $display("test_disable done");
   endtask

   initial begin
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      #1;
      test_reset();
      test_enable();
      test_wave();
      test_sync();
      test_disable();
      complete_run();
   end

   // Whole run is under two hundred cycles; this leaves a wide margin
   initial begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      complete_run();
   end
endmodule
